// ### rtl/dpl_host_ctrl.v
// Purpose: host controller driving a parallel-load converter's pins
// Assumes: classic Wishbone slave, 32-bit data, 10 MHz clock
// Notes:   pins other than sleep_n_o held stable around every write strobe edge
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "dpl_regs.vh"

// Overview of operation
// - write only with select and write low
// - upper_byte_select steers byte on byte variant
// - sync update falls inside write, rises after
// - async update released before write rises
// - data and selects stable around write edge
module dpl_host_ctrl #(
  parameter CODE_W = 12,        // 8, 10 or 12
  parameter BUS_W = 12          // pins on the data bus, 8 for byte variant
) (
  input wire clk_i,             // system clock
  input wire rst_i,             // synchronous reset, high
  input wire wb_cyc_i,          // wishbone cycle
  input wire wb_stb_i,          // wishbone strobe
  input wire wb_we_i,           // wishbone write
  input wire [3:0] wb_adr_i,    // wishbone byte address
  input wire [3:0] wb_sel_i,    // wishbone byte lanes
  input wire [31:0] wb_dat_i,   // wishbone write data
  output reg [31:0] wb_dat_o,   // wishbone read data
  output reg wb_ack_o,          // wishbone acknowledge
  output wire select_n_o,       // device select, low active
  output wire write_n_o,        // write strobe, low active
  output wire output_update_n_o, // update strobe, low active
  output wire zeroing_input_n_o, // clear, low active
  output reg sleep_n_o,         // power-down, low active
  output reg buffer_sel_o,      // reference buffer on
  output reg gain_sel_o,        // double output range
  output reg upper_byte_select_o, // byte variant: high byte
  output reg [BUS_W-1:0] parallel_code_o // data pins, msb highest
);

  reg [31:0] ctrl;
  reg [CODE_W-1:0] code;
  reg [1:0] phase;              // byte variant: bytes left
  reg start;
  reg [1:0] kind;
  wire busy;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [31:0] code_merged;      // code register after byte lanes
  wire cmd_ok;                  // command accepted this cycle

  // sequence kinds handed to the pin sequencer
  localparam KIND_WRITE = 2'd0;
  localparam KIND_UPDATE = 2'd1;
  localparam KIND_CLEAR = 2'd2;

  // byte lanes to merge on write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // register address decode, shared by read and write paths
  function hit;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  // ==========================================================
  // sequencer instance
  dpl_strobe_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .kind_i(kind),
    .sync_i(ctrl[`DPL_CTRL_SYNC]),
    .select_n_o(select_n_o),
    .write_n_o(write_n_o),
    .update_n_o(output_update_n_o),
    .clear_n_o(zeroing_input_n_o),
    .busy_o(busy)
  );

  // ==========================================================
  // write data merge and command acceptance
  assign code_merged = merge({{(32-CODE_W){1'b0}}, code}, wb_dat_i,
                             wb_sel_i);
  // commands are taken only while nothing is in flight
  assign cmd_ok = wr && hit(wb_adr_i, `DPL_CMD_OFS) && !busy && !start
                  && phase == 2'h0 && wb_sel_i[0];

  // ==========================================================
  // bus answer: ack one cycle after the request, read data with it
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (hit(wb_adr_i, `DPL_CTRL_OFS))
          wb_dat_o <= ctrl;
        else if (hit(wb_adr_i, `DPL_CODE_OFS))
          wb_dat_o <= {{(32-CODE_W){1'b0}}, code};
        else if (hit(wb_adr_i, `DPL_STAT_OFS))
          wb_dat_o <= {31'h0, busy | start | (|phase)};
      end
    end
  end

  // control and code registers, byte lanes honoured
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `DPL_CTRL_RST;
      code <= {CODE_W{1'b0}};
    end else begin
      if (wr && hit(wb_adr_i, `DPL_CTRL_OFS))
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_000F;
      if (wr && hit(wb_adr_i, `DPL_CODE_OFS))
        code <= code_merged[CODE_W-1:0];
    end
  end

  // ==========================================================
  // command issue: clear wins over write, write over update
  always @(posedge clk_i) begin
    if (rst_i) begin
      start <= 1'b0;
      kind <= KIND_WRITE;
      phase <= 2'h0;
    end else begin
      start <= 1'b0;
      // commands ignored while a sequence is running
      if (cmd_ok) begin
        if (wb_dat_i[`DPL_CMD_CLEAR]) begin
          kind <= KIND_CLEAR;
          start <= 1'b1;
        end else if (wb_dat_i[`DPL_CMD_WRITE]) begin
          kind <= KIND_WRITE;
          start <= 1'b1;
          phase <= (BUS_W < CODE_W) ? 2'd2 : 2'd1;
        end else if (wb_dat_i[`DPL_CMD_UPDATE]) begin
          kind <= KIND_UPDATE;
          start <= 1'b1;
        end
      end
      // second byte of a byte-wide write follows the first
      if (!start && !busy && phase == 2'd1 && BUS_W < CODE_W
          && kind == KIND_WRITE && upper_byte_select_o) begin
        start <= 1'b1;
      end
      if (start && kind == KIND_WRITE && phase != 2'h0)
        phase <= phase - 2'd1;
    end
  end

  // ==========================================================
  // buffer and gain pins set before select and held to the end; sleep follows ctrl every cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      sleep_n_o <= 1'b1;
      buffer_sel_o <= 1'b0;
      gain_sel_o <= 1'b0;
    end else begin
      sleep_n_o <= ~ctrl[`DPL_CTRL_SLEEP];
      if (!busy && !start) begin
        buffer_sel_o <= ctrl[`DPL_CTRL_BUF];
        gain_sel_o <= ctrl[`DPL_CTRL_GAIN];
      end
    end
  end

  // ==========================================================
  // data pins and byte steering, frozen while a sequence runs
  always @(posedge clk_i) begin
    if (rst_i) begin
      upper_byte_select_o <= 1'b0;
      parallel_code_o <= {BUS_W{1'b0}};
    end else begin
      if (!busy && !start) begin
        if (BUS_W < CODE_W) begin
          // high byte first, then low byte
          upper_byte_select_o <= (phase == 2'd2) ||
            (phase == 2'd0 && wr && wb_adr_i == `DPL_CMD_OFS);
          if (phase == 2'd1 && upper_byte_select_o)
            upper_byte_select_o <= 1'b0;
          parallel_code_o <= upper_byte_select_o && phase == 2'd1
            ? code[BUS_W-1:0]
            : code[CODE_W-1 -: BUS_W] >> 0;
          if (phase == 2'd0)
            parallel_code_o <= code[CODE_W-1 -: BUS_W] >> (2*BUS_W-CODE_W);
        end else begin
          parallel_code_o <= code[BUS_W-1:0];
        end
      end
    end
  end

endmodule // dpl_host_ctrl
`default_nettype wire

// ### rtl/dpl_regs.vh
// Purpose: register map, field positions and timing counts of the
//          parallel-load converter controller
// Assumes: 10 MHz clock, 100 ns per cycle
// Notes:   byte offsets on a 32-bit classic Wishbone slave
`ifndef DPL_REGS_VH
`define DPL_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define DPL_CTRL_OFS 4'h0
`define DPL_CODE_OFS 4'h4
`define DPL_CMD_OFS 4'h8
`define DPL_STAT_OFS 4'hC

// ==========================================================
// control fields
`define DPL_CTRL_SLEEP 0
`define DPL_CTRL_BUF 1
`define DPL_CTRL_GAIN 2
`define DPL_CTRL_SYNC 3
`define DPL_CTRL_RST 32'h0000_0000

// ==========================================================
// command fields (write only, self clearing)
`define DPL_CMD_WRITE 0
`define DPL_CMD_UPDATE 1
`define DPL_CMD_CLEAR 2

// ==========================================================
// status fields
`define DPL_STAT_BUSY 0

// ==========================================================
// timing: least strobe width and spacing, in ns and cycles
`define DPL_CLK_NS 100
`define DPL_STROBE_NS 20
`define DPL_GAP_NS 50
`define DPL_STROBE_CYC ((`DPL_STROBE_NS + `DPL_CLK_NS - 1) / `DPL_CLK_NS)
`define DPL_GAP_CYC ((`DPL_GAP_NS + `DPL_CLK_NS - 1) / `DPL_CLK_NS)

`endif

// ### rtl/dpl_strobe_seq.v
// Purpose: pin sequencer that plays one write, update or clear cycle
// Assumes: 10 MHz clock; every step lasts at least one cycle
// Notes:   each write step is one clock apart, update and select rise together, well above all setups
`timescale 1ns/10ps
`default_nettype none
`include "dpl_regs.vh"

module dpl_strobe_seq #(
  parameter STROBE_CYC = `DPL_STROBE_CYC,
  parameter GAP_CYC = `DPL_GAP_CYC
) (
  input wire clk_i,             // system clock
  input wire rst_i,             // synchronous reset, high
  input wire start_i,           // one-cycle request
  input wire [1:0] kind_i,      // 0 write, 1 update, 2 clear
  input wire sync_i,            // update in step with write
  output reg select_n_o,        // device select pin
  output reg write_n_o,         // write strobe pin
  output reg update_n_o,        // output_update_n pin
  output reg clear_n_o,         // zeroing_input_n pin
  output reg busy_o             // sequence running
);

  localparam S_IDLE = 3'd0;
  localparam S_SEL = 3'd1;
  localparam S_WLOW = 3'd2;
  localparam S_WHIGH = 3'd3;
  localparam S_REL = 3'd4;
  localparam S_PULSE = 3'd5;
  localparam S_GAP = 3'd6;

  reg [2:0] state;
  reg [7:0] cnt;
  reg [1:0] kind;
  reg sync;

  // ==========================================================
  // sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      kind <= 2'h0;
      sync <= 1'b0;
      select_n_o <= 1'b1;
      write_n_o <= 1'b1;
      update_n_o <= 1'b1;
      clear_n_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_i) begin
            busy_o <= 1'b1;
            kind <= kind_i;
            sync <= sync_i;
            cnt <= STROBE_CYC[7:0];
            if (kind_i == 2'd0) begin
              select_n_o <= 1'b0;
              state <= S_SEL;
            end else begin
              if (kind_i == 2'd1)
                update_n_o <= 1'b0;
              else
                clear_n_o <= 1'b0;
              state <= S_PULSE;
            end
          end
        end
        S_SEL: begin
          write_n_o <= 1'b0;
          state <= S_WLOW;
        end
        S_WLOW: begin
          // in sync mode update falls after write falls
          if (sync)
            update_n_o <= 1'b0;
          if (cnt > 8'h01)
            cnt <= cnt - 8'h01;
          else
            state <= S_WHIGH;
        end
        S_WHIGH: begin
          write_n_o <= 1'b1; // data captured at this rising edge
          state <= S_REL;
        end
        S_REL: begin
          // update released only after write has risen
          update_n_o <= 1'b1;
          select_n_o <= 1'b1;
          cnt <= GAP_CYC[7:0];
          state <= S_GAP;
        end
        S_PULSE: begin
          if (cnt > 8'h01)
            cnt <= cnt - 8'h01;
          else begin
            update_n_o <= 1'b1;
            clear_n_o <= 1'b1;
            cnt <= GAP_CYC[7:0];
            state <= S_GAP;
          end
        end
        S_GAP: begin
          if (cnt > 8'h01)
            cnt <= cnt - 8'h01;
          else begin
            busy_o <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // dpl_strobe_seq
`default_nettype wire

// ### verification/dpl_checker.sv
// Purpose: pin and bus checks for dpl_host_ctrl
// Assumes: one clock, synchronous reset high
// Notes:   bound to the top module below
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// checker
module dpl_checker #(
  parameter BUS_W = 12
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic select_n_o, // select
  input wire logic write_n_o, // write strobe
  input wire logic output_update_n_o, // update strobe
  input wire logic zeroing_input_n_o, // clear
  input wire logic sleep_n_o, // sleep
  input wire logic gain_sel_o, // gain
  input wire logic buffer_sel_o, // buffer
  input wire logic [BUS_W-1:0] parallel_code_o // data pins
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request and answer steps
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_once_a: assert property (taken_s |=> ack_pulse_s)
    else $error("ack not one cycle after request");
  sel_write_a: assert property (!write_n_o |-> !select_n_o)
    else $error("write strobe without select");
  wr_capture_a: assert property ($rose(write_n_o) |-> !select_n_o)
    else $error("select gone at write rise");
  data_hold_a: assert property ($rose(write_n_o) |->
    $stable(parallel_code_o) && $stable(gain_sel_o) && $stable(buffer_sel_o)
    ##1 $stable(parallel_code_o))
    else $error("data moved around write edge");
  wr_gap_a: assert property ($rose(write_n_o) |=> write_n_o)
    else $error("write strobes too close");
  upd_edge_a: assert property ($rose(write_n_o) |->
    !$fell(output_update_n_o) && !$rose(output_update_n_o))
    else $error("update moved with write rise");
  clr_pulse_a: assert property ($fell(zeroing_input_n_o) |=> zeroing_input_n_o)
    else $error("clear pulse not one cycle");
  idle_pins_a: assert property ($fell(rst_i) |-> write_n_o && select_n_o
    && output_update_n_o && zeroing_input_n_o && sleep_n_o)
    else $error("pins not idle after reset");
endmodule // dpl_checker

bind dpl_host_ctrl dpl_checker #(.BUS_W(BUS_W)) u_dpl_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .select_n_o(select_n_o), .write_n_o(write_n_o),
  .output_update_n_o(output_update_n_o),
  .zeroing_input_n_o(zeroing_input_n_o), .sleep_n_o(sleep_n_o),
  .gain_sel_o(gain_sel_o), .buffer_sel_o(buffer_sel_o),
  .parallel_code_o(parallel_code_o));
`default_nettype wire

// ### verification/dpl_dac_model.sv
// Purpose: behavioural model of the parallel-load converter
// Assumes: full-width variant, msb on highest pin
// Notes:   level is the code scaled by gain, zero when asleep
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// device model
module dpl_dac_model #(
  parameter W = 12
) (
  input wire logic select_n_i, // select
  input wire logic write_n_i, // write strobe
  input wire logic update_n_i, // update strobe
  input wire logic clear_n_i, // clear
  input wire logic sleep_n_i, // sleep
  input wire logic buf_i, // buffer select
  input wire logic gain_i, // gain select
  input wire logic [W-1:0] code_i, // data pins
  output logic [W-1:0] in_reg_o, // input register
  output logic [W-1:0] dac_o, // dac register
  output logic [W:0] level_o, // output level
  output logic ref_buf_o // reference buffered
);
  logic [W-1:0] in_reg = '0;
  logic [W-1:0] dac_reg = '0;
  // input register loads on the write rising edge while selected
  always @(posedge write_n_i or negedge clear_n_i) begin
    if (!clear_n_i) in_reg <= '0;
    else if (!select_n_i) in_reg <= code_i;
  end
  // dac register follows the input register while update is low
  always @* begin
    if (!clear_n_i) dac_reg = '0;
    else if (!update_n_i) dac_reg = in_reg;
  end
  assign level_o = sleep_n_i ? ({1'b0, dac_reg} << gain_i) : '0;
  assign ref_buf_o = buf_i;
  assign in_reg_o = in_reg;
  assign dac_o = dac_reg;
endmodule // dpl_dac_model
`default_nettype wire

// ### verification/dpl_host_ctrl_tb.sv
// Purpose: self-checking bench for dpl_host_ctrl
// Assumes: 10 MHz clock, full-width 12-bit device
// Notes:   rows load mode and code, awkward cases follow
`timescale 1ns/10ps
`default_nettype none
`include "dpl_regs.vh"
// ==========================================
// bench
module dpl_host_ctrl_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, rd, rd_o;
  wire logic ack, sn, wn, un, cn, pn, bs, gs, ub, rb;
  wire logic [11:0] pc, dac, inr;
  wire logic [12:0] lvl;
  logic [3:0] m;
  logic [11:0] c, prev;
  logic [12:0] e;
  int bad_count = 0, total_checks = 0, cyc_cnt = 0;
  // rows: mode, code, expected level
  logic [28:0] rows [4] = '{{4'h8, 12'hFFF, 13'h0FFF},
    {4'hC, 12'h800, 13'h1000}, {4'h2, 12'h001, 13'h0001},
    {4'h5, 12'h123, 13'h0000}};
  dpl_host_ctrl u_dpl_host_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .select_n_o(sn), .write_n_o(wn), .output_update_n_o(un),
    .zeroing_input_n_o(cn), .sleep_n_o(pn), .buffer_sel_o(bs),
    .gain_sel_o(gs), .upper_byte_select_o(ub), .parallel_code_o(pc));
  dpl_dac_model u_dpl_dac_model (.select_n_i(sn), .write_n_i(wn),
    .update_n_i(un), .clear_n_i(cn), .sleep_n_i(pn), .buf_i(bs),
    .gain_i(gs), .code_i(pc), .in_reg_o(inr), .dac_o(dac), .level_o(lvl),
    .ref_buf_o(rb));
  // clock and hang guard
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      bad_count++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] x, input logic [31:0] s,
                     input string nm);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // wait for ack; only the cycle guard ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rd_o;
    cyc <= 1'b0;
  endtask
  // command then wait for busy to drop
  task automatic go(input logic [2:0] k);
    int n;
    bus(1'b1, `DPL_CMD_OFS, {29'h0, k});
    n = 0;
    do begin
      bus(1'b0, `DPL_STAT_OFS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1, "busy");
  endtask
  task automatic close_out;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `DPL_CTRL_OFS, 32'h0);
    chk(`DPL_CTRL_RST, rd, "ctrl");
    chk(32'h0, {20'h0, dac}, "dac0");
    bus(1'b0, 4'h2, 32'h0);
    chk(32'h0, rd, "unmapped");
    prev = 12'h0;
    for (int i = 0; i < 4; i++) begin
      {m, c, e} = rows[i];
      bus(1'b1, `DPL_CTRL_OFS, {28'h0, m});
      bus(1'b1, `DPL_CODE_OFS, {20'h0, c});
      bus(1'b0, `DPL_CODE_OFS, 32'h0);
      chk({20'h0, c}, rd, "code");
      if (m[3]) go(3'h3);
      else begin
        go(3'h1);
        chk({20'h0, prev}, {20'h0, dac}, "held");
        go(3'h2);
      end
      chk({20'h0, c}, {20'h0, dac}, "dac");
      chk({19'h0, e}, {19'h0, lvl}, "level");
      chk({29'h0, m[2:1], ~m[0]}, {29'h0, gs, rb, pn}, "pins");
      chk(32'h0, {31'h0, ub}, "upper");
      prev = c;
    end
    go(3'h4);
    chk(32'h0, {inr, dac}, "clear");
    bus(1'b1, `DPL_CODE_OFS, 32'h555);
    go(3'h7);
    chk(32'h0, {inr, dac}, "clrwin");
    go(3'h3);
    chk(32'h555, {20'h0, inr}, "reload_in");
    go(3'h2);
    chk(32'h555, {20'h0, dac}, "reload");
    // reset after the last sequence: control register and sleep pin back to reset values
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `DPL_CTRL_OFS, 32'h0);
    chk(`DPL_CTRL_RST, rd, "ctrl_rst");
    chk(32'h1, {31'h0, pn}, "sleep_rst");
    close_out;
  end
endmodule // dpl_host_ctrl_tb
`default_nettype wire
